/* File: bench/asst_conv_model.sv */
// Converter stand-in: answers each start pulse after a set latency.
// Assumes start pulses last one cycle on the bench clock.
`default_nettype none

// ==========
// Model
module asst_conv_model (
  input  wire logic        i_clk,
  input  wire logic        i_start,
  input  wire logic [7:0]  i_mux,
  input  wire logic [7:0]  i_lat,
  output wire logic        o_done,
  output wire logic [23:0] o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  int          cnt = 0;
  logic        dn  = 1'b0;
  logic [23:0] val = 24'h000000;
  logic [23:0] bus = 24'hffffff;
  assign o_done = dn;
  assign o_data = bus;
  // Bus flips outside the done cycle, so a late sample never matches
  always @(posedge i_clk) begin
    dn <= 1'b0;
    bus <= ~val;
    if (i_start) begin
      cnt <= i_lat;
      val <= {16'hc3a5, i_mux};
    end else if (cnt == 1) begin
      dn <= 1'b1;
      bus <= val;
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire

/* File: bench/asst_scan_seq_assertions.sv */
// Concurrent checks on the scan sequencer top-level ports.
// Assumes full-rate decimation ticks whenever a cycle gap or a wake-up is timed.
`default_nettype none

// ==========
// Checker
module asst_scan_chk (
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        i_reg_rd,
  input wire logic [3:0]  i_reg_addr,
  input wire logic        i_conv_done,
  input wire logic [23:0] i_conv_data,
  input wire logic [23:0] o_reg_rdata,
  input wire logic        o_conv_start,
  input wire logic [7:0]  o_mux_sel,
  input wire logic [2:0]  o_gain_sel,
  input wire logic        o_offset_short,
  input wire logic [1:0]  o_power_state,
  input wire logic        o_data_ready,
  input wire logic [23:0] o_data,
  input wire logic        o_scan_active
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  AST_SUPPLY_GAIN: assert property (o_conv_start && o_mux_sel == 8'h98 |-> o_gain_sel == 3'h0)
    else $error("supply gain wrong");
  AST_TEMP_GAIN: assert property (o_conv_start && o_mux_sel == 8'hde |-> o_gain_sel == 3'h1)
    else $error("temperature gain wrong");
  AST_CMODE_GAIN: assert property (o_conv_start && o_mux_sel == 8'hf8 |-> o_gain_sel == 3'h1)
    else $error("common-mode gain wrong");
  AST_OFFSET_SHORT: assert property (o_conv_start && o_mux_sel == 8'h88 |-> o_offset_short)
    else $error("offset input not shorted");
  AST_RESULT: assert property (i_conv_done && o_scan_active |=> o_data_ready && o_data == $past(i_conv_data))
    else $error("result not presented");
  AST_DATA_HOLD: assert property (!o_data_ready |-> $stable(o_data))
    else $error("data moved without ready");
  // Ready cycle excluded: the sequencer may already be idle there
  AST_FIELD_ACTIVE: assert property (i_reg_rd && i_reg_addr == 4'h1 && o_scan_active && !o_data_ready
    |=> o_reg_rdata[1:0] == 2'h3)
    else $error("power field not read as active");
  AST_SHUT_AT_END: assert property ($past(o_power_state) == 2'h3 && o_power_state == 2'h0 |-> o_data_ready)
    else $error("shutdown outside cycle end");
  AST_WAKE_LEAD: assert property ($past(o_power_state) == 2'h0 && o_power_state == 2'h3 && o_scan_active
    |-> ##[250:262] o_conv_start)
    else $error("wake not one setup time ahead");
  AST_DELAY_STANDBY: assert property (o_data_ready && !o_conv_start && o_power_state != 2'h0
    |-> o_power_state == 2'h2)
    else $error("not standby while waiting");
  AST_START_ACTIVE: assert property (o_conv_start |-> o_power_state == 2'h3)
    else $error("start while powered down");
  cover property (o_conv_start && o_mux_sel == 8'h98);
  cover property (o_power_state == 2'h0 && o_scan_active);
  cover property (o_data_ready && o_power_state == 2'h2);
endmodule

bind asst_scan_seq asst_scan_chk u_chk (.*);
`default_nettype wire

/* File: bench/asst_scan_seq_tb_top.sv */
// Self-checking bench for the scan sequencer with a converter stand-in.
// Assumes one decimation tick per clock except in the half-rate delay pass; delays are counted in cycles.
`default_nettype none

// ==========
// Bench
module asst_scan_seq_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk;
  logic        i_rst = 1'b1, wr = 1'b0, rd = 1'b0, done, start, rdy, shrt, act;
  logic [3:0]  adr = 4'h0, cid;
  logic [7:0]  mux, lat = 8'h03;
  logic [2:0]  gain;
  logic [1:0]  pwr;
  logic [23:0] wd = 24'h000000, rdat, cdat, dat, offc, v;
  int          errors = 0, compares = 0, cyc = 0;
  logic        half = 1'b0, tick = 1'b1;
  // Half-rate ticks prove delays count decimation periods, not cycles
  always @(negedge i_clk) tick <= half ? ~tick : 1'b1;

  asst_scan_seq uut (.i_clk(i_clk), .i_rst(i_rst), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(adr),
    .i_reg_wdata(wd), .o_reg_rdata(rdat), .i_decimation_clock_tick(tick), .i_conv_done(done), .i_conv_data(cdat),
    .o_conv_start(start), .o_mux_sel(mux), .o_gain_sel(gain), .o_offset_short(shrt), .o_power_state(pwr),
    .o_data_ready(rdy), .o_data(dat), .o_chan_id(cid), .o_offset_correction(offc), .o_scan_active(act));
  asst_conv_model cnv (.i_clk(i_clk), .i_start(start), .i_mux(mux), .i_lat(lat), .o_done(done), .o_data(cdat));

  task automatic chk(input string n, input logic [23:0] g, input logic [23:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic summarize;
    if (errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [23:0] d);
    @(negedge i_clk);
    wr = 1'b1;
    adr = a;
    wd = d;
    @(negedge i_clk);
    wr = 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a);
    @(negedge i_clk);
    rd = 1'b1;
    adr = a;
    @(negedge i_clk);
    rd = 1'b0;
    @(negedge i_clk);
    v = rdat;
  endtask
  // Ready is a one-cycle pulse, so it is sampled every falling edge
  task automatic wrdy;
    int k;
    k = 0;
    do begin
      @(negedge i_clk);
      k++;
    end while (rdy !== 1'b1 && k < 2000);
    chk("ready", 24'(k < 2000), 24'h1);
  endtask
  // Counting window allows for registered start and ready lags
  task automatic gap(input int g0, input int e, input string n);
    int g;
    g = g0;
    while (start !== 1'b1 && g < 1000) begin
      @(negedge i_clk);
      g++;
    end
    chk(n, 24'(g >= e - 1 && g <= e + 2), 24'h1);
  endtask

  // ==========
  // Scenarios
  task automatic t_regs;
    rreg(4'h8);
    chk("interval reset", v, 24'h000000);
    wreg(4'h8, 24'hffffff);
    rreg(4'h8);
    chk("interval max", v, 24'hffffff);
    rreg(4'h3);
    chk("unmapped", v, 24'h000000);
  endtask
  task automatic t_scan;
    logic [7:0]  m [5] = '{8'h88, 8'hf8, 8'h98, 8'hde, 8'h08};
    logic [3:0]  c [5] = '{4'hf, 4'he, 4'hd, 4'hc, 4'h0};
    logic [23:0] off;
    lat = 8'h14;
    wreg(4'h7, 24'h00f001);
    wreg(4'h1, 24'h000013);
    if (start !== 1'b1) @(negedge i_clk);
    chk("first start", 24'(start), 24'h1);
    chk("offset short", 24'(shrt), 24'h1);
    off = 24'h000000;
    for (int i = 0; i < 5; i++) begin
      wrdy();
      chk("chan order", 24'(cid), 24'(c[i]));
      chk("result", dat, {16'hc3a5, m[i]});
      if (i == 0) off = dat;
    end
    rreg(4'h1);
    chk("gain kept", 24'(v[4:2]), 24'h4);
    chk("one pass idles", 24'(v[1:0]), 24'h2);
    wreg(4'h9, -off);
    @(negedge i_clk);
    chk("offset corr", offc, -off);
  endtask
  task automatic t_delay;
    lat = 8'h02;
    for (int c = 1; c < 8; c += 6) begin
      half = (c == 1);
      wreg(4'h7, 24'(c) << 21 | 24'h000003);
      wreg(4'h1, 24'h000007);
      wrdy();
      @(negedge i_clk);
      chk("mux early", 24'(mux), 24'h08);
      chk("delay power", 24'(pwr), 24'h2);
      rreg(4'h1);
      chk("delay field", 24'(v[1:0]), 24'h3);
      gap(4, (c == 1) ? 16 : (4 << c), "intra delay");
      half = 1'b0;
      wrdy();
    end
  endtask
  task automatic t_cont;
    int iv [3] = '{300, 256, 5};
    wreg(4'h7, 24'h000001);
    for (int i = 0; i < 3; i++) begin
      wreg(4'h8, 24'(iv[i]));
      wreg(4'h1, 24'h0000c7);
      wrdy();
      @(negedge i_clk);
      chk("gap power", 24'(pwr), iv[i] > 256 ? 24'h0 : 24'h2);
      if (iv[i] > 256) begin
        rreg(4'h1);
        chk("gap field", 24'(v[1:0]), 24'h3);
      end
      gap(iv[i] > 256 ? 4 : 1, iv[i], "cycle gap");
      wreg(4'h1, 24'h000007);
      wrdy();
    end
  endtask

  // ==========
  // Clock, watchdog, sequence
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc > 6000) begin
      errors++;
      summarize();
    end
  end
  initial begin
    repeat (4) @(posedge i_clk);
    @(negedge i_clk);
    i_rst = 1'b0;
    t_regs();
    t_scan();
    t_delay();
    t_cont();
    summarize();
  end
endmodule
`default_nettype wire

/* File: include/asst_regs.vh */
// Register offsets, field positions, codes and timing counts of the scan sequencer.
// Assumes it is included only by the sequencer top-level design file.
`ifndef ASST_REGS_VH
`define ASST_REGS_VH

// ==================================================
// Register offsets
`define ASST_ADDR_CONFIG      4'h1
`define ASST_ADDR_SCAN        4'h7
`define ASST_ADDR_INTERVAL    4'h8
`define ASST_ADDR_OFFCORR     4'h9

// ==================================================
// Primary configuration field positions
`define ASST_CFG_PWR_LSB      0
`define ASST_CFG_PWR_MSB      1
`define ASST_CFG_GAIN_LSB     2
`define ASST_CFG_GAIN_MSB     4
`define ASST_CFG_REP_LSB      6
`define ASST_CFG_REP_MSB      7

// ==================================================
// Scan register field positions
`define ASST_SCAN_MASK_LSB    0
`define ASST_SCAN_MASK_MSB    15
`define ASST_SCAN_DLY_LSB     21
`define ASST_SCAN_DLY_MSB     23

// ==================================================
// Reset values
`define ASST_RST_PWR          2'h0
`define ASST_RST_GAIN         3'h1
`define ASST_RST_REP          2'h0
`define ASST_RST_MASK         16'h0000
`define ASST_RST_DLY          3'h0
`define ASST_RST_INTERVAL     24'h000000
`define ASST_RST_OFFCORR      24'h000000

// ==================================================
// Power states and repeat code
`define ASST_PWR_SHUTDOWN     2'h0
`define ASST_PWR_STANDBY      2'h2
`define ASST_PWR_ACTIVE       2'h3
`define ASST_REP_CONTINUOUS   2'h3

// ==================================================
// Gain codes, channel numbers and multiplexer codes
`define ASST_GAIN_THIRD       3'h0
`define ASST_GAIN_ONE         3'h1
`define ASST_CH_OFFSET        4'hf
`define ASST_CH_CMODE         4'he
`define ASST_CH_SUPPLY        4'hd
`define ASST_CH_TEMP          4'hc
`define ASST_MUX_OFFSET       8'h88
`define ASST_MUX_CMODE        8'hf8
`define ASST_MUX_SUPPLY       8'h98
`define ASST_MUX_TEMP         8'hde
`define ASST_MUX_DIFF_D       8'h67
`define ASST_MUX_DIFF_C       8'h45
`define ASST_MUX_DIFF_B       8'h23
`define ASST_MUX_DIFF_A       8'h01
`define ASST_MUX_SE_LOW       4'h8

// ==================================================
// Timing counts, in decimation clock periods
`define ASST_SETUP_PERIODS    24'h000100
`define ASST_DLY_BASE         24'h000004

`endif

/* File: rtl/asst_dcnt.v */
// Loadable down-counter stepped by the decimation clock tick.
// Assumes the tick is a one-cycle pulse from logic on the same clock.
`default_nettype none

module asst_dcnt (
  input  wire        i_clk,
  input  wire        i_rst,
  input  wire        i_load,
  input  wire [23:0] i_load_val,
  input  wire        i_tick,
  output reg  [23:0] o_count,
  output wire        o_zero
);

  assign o_zero = (o_count == 24'h000000);

  // ==================================================
  // Load wins over a tick; holds at zero
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_count <= 24'h000000;
    end else if (i_load) begin
      o_count <= i_load_val;
    end else if (i_tick && !o_zero) begin
      o_count <= o_count - 24'h000001;
    end
  end

endmodule

`default_nettype wire

/* File: rtl/asst_pick.v */
// Priority picker: highest set mask bit strictly below a limit position.
// Assumes a registered mask; purely combinational.
`default_nettype none

module asst_pick (
  input  wire [15:0] i_mask,
  input  wire [4:0]  i_limit,
  output reg         o_found,
  output reg  [3:0]  o_idx
);

  integer i;

  // ==================================================
  // Ascending scan, so the last hit is the highest bit
  always @* begin
    o_found = 1'b0;
    o_idx   = 4'h0;
    for (i = 0; i < 16; i = i + 1) begin
      if (i_mask[i] && (i < i_limit)) begin
        o_found = 1'b1;
        o_idx   = i[3:0];
      end
    end
  end

endmodule

`default_nettype wire

/* File: rtl/asst_scan_seq.v */
// Scan sequencer: channel order, internal channel overrides, delays and power states.
// Assumes the register port, tick and conversion-done come from logic on i_clk.
//
// What this block does
// - Supply channel: mux 0x98, gain third
// - Overrides never alter stored register contents
// - Temperature channel: mux 0xDE, unity gain
// - Offset channel shorts mux output to ground
// - Common-mode channel: mux 0xF8, unity gain
// - Delay code: zero, then 8 doubling to 512
// - Delay only between conversions of cycle
// - Standby during delay, field reads 11
// - Mux switches to next input at conversion end
// - Continuous cycles separated by programmed interval
// - Interval is 24-bit unsigned period count
// - Counter loads interval, counts down, relaunches
// - Interval above setup time: shutdown in gap
// - Counter at 256 powers converter up
// - Interval below setup time: standby in gap
// - Power field reads 11 throughout scanning
// - Channels converted from highest bit downward
// - Repeat only when repeat code equals 11
// - Each result updates data and flags ready
`default_nettype none
`include "asst_regs.vh"

module asst_scan_seq (
  input  wire        i_clk,
  input  wire        i_rst,
  input  wire        i_reg_wr,
  input  wire        i_reg_rd,
  input  wire [3:0]  i_reg_addr,
  input  wire [23:0] i_reg_wdata,
  output reg  [23:0] o_reg_rdata,
  input  wire        i_decimation_clock_tick,
  input  wire        i_conv_done,
  input  wire [23:0] i_conv_data,
  output reg         o_conv_start,
  output reg  [7:0]  o_mux_sel,
  output reg  [2:0]  o_gain_sel,
  output reg         o_offset_short,
  output reg  [1:0]  o_power_state,
  output reg         o_data_ready,
  output reg  [23:0] o_data,
  output reg  [3:0]  o_chan_id,
  output reg  [23:0] o_offset_correction,
  output reg         o_scan_active
);

  // ==================================================
  // States
  localparam ST_IDLE = 4'b0001;
  localparam ST_CONV = 4'b0010;
  localparam ST_DLY  = 4'b0100;
  localparam ST_GAP  = 4'b1000;

  // ==================================================
  // Registers
  reg [3:0]  state;
  reg [3:0]  cur_chan;
  reg        gap_shutdown;
  reg [1:0]  cfg_power;
  reg [2:0]  cfg_gain;
  reg [1:0]  conversion_repeat_select;
  reg [15:0] scan_mask;
  reg [2:0]  intra_scan_delay;
  reg [23:0] scan_cycle_interval;
  reg [23:0] offset_correction_value;

  wire       next_found;
  wire [3:0] next_idx;
  wire       first_found;
  wire [3:0] first_idx;
  wire [23:0] cnt_count;
  wire        cnt_zero;

  // ==================================================
  // Channel search
  asst_pick u_pick_next (
    .i_mask  (scan_mask),
    .i_limit ({1'b0, cur_chan}),
    .o_found (next_found),
    .o_idx   (next_idx)
  );

  asst_pick u_pick_first (
    .i_mask  (scan_mask),
    .i_limit (5'h10),
    .o_found (first_found),
    .o_idx   (first_idx)
  );

  // ==================================================
  // Decisions
  // Start only from idle; later config writes just store fields
  // Interval of zero relaunches with no gap at all
  wire        wr_config   = i_reg_wr && (i_reg_addr == `ASST_ADDR_CONFIG);
  wire        start_req   = wr_config && (state == ST_IDLE) && first_found &&
                            (i_reg_wdata[`ASST_CFG_PWR_MSB:`ASST_CFG_PWR_LSB] == `ASST_PWR_ACTIVE);
  wire        conv_end    = (state == ST_CONV) && i_conv_done;
  wire        repeat_on   = (conversion_repeat_select == `ASST_REP_CONTINUOUS);
  wire        dly_used    = (intra_scan_delay != 3'h0);
  wire [23:0] dly_periods = dly_used ? (`ASST_DLY_BASE << intra_scan_delay) : 24'h000000;
  wire        dly_load    = conv_end && next_found && dly_used;
  wire        gap_load    = conv_end && !next_found && repeat_on && (scan_cycle_interval != 24'h000000);
  wire        cnt_load    = dly_load || gap_load;
  wire [23:0] cnt_val     = dly_load ? dly_periods : scan_cycle_interval;
  wire        dly_done    = (state == ST_DLY) && cnt_zero;
  wire        gap_done    = (state == ST_GAP) && cnt_zero;
  wire        relaunch    = conv_end && !next_found && repeat_on && (scan_cycle_interval == 24'h000000);
  wire        launch      = start_req || gap_done || relaunch;

  // One counter serves both delays; they never overlap
  asst_dcnt u_dcnt (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .i_load     (cnt_load),
    .i_load_val (cnt_val),
    .i_tick     (i_decimation_clock_tick),
    .o_count    (cnt_count),
    .o_zero     (cnt_zero)
  );

  // ==================================================
  // Channel table
  // Internal channels first; single-ended codes built from the index
  function [7:0] chan_mux;
    input [3:0] ch;
    begin
      if (ch == `ASST_CH_OFFSET) begin
        chan_mux = `ASST_MUX_OFFSET;
      end else if (ch == `ASST_CH_CMODE) begin
        chan_mux = `ASST_MUX_CMODE;
      end else if (ch == `ASST_CH_SUPPLY) begin
        chan_mux = `ASST_MUX_SUPPLY;
      end else if (ch == `ASST_CH_TEMP) begin
        chan_mux = `ASST_MUX_TEMP;
      end else if (ch == 4'hb) begin
        chan_mux = `ASST_MUX_DIFF_D;
      end else if (ch == 4'ha) begin
        chan_mux = `ASST_MUX_DIFF_C;
      end else if (ch == 4'h9) begin
        chan_mux = `ASST_MUX_DIFF_B;
      end else if (ch == 4'h8) begin
        chan_mux = `ASST_MUX_DIFF_A;
      end else begin
        chan_mux = {ch, `ASST_MUX_SE_LOW};
      end
    end
  endfunction

  // Forced gain lives only on the output; cfg_gain is never touched
  function [2:0] chan_gain;
    input [3:0] ch;
    input [2:0] prog;
    begin
      if (ch == `ASST_CH_SUPPLY) begin
        chan_gain = `ASST_GAIN_THIRD;
      end else if ((ch == `ASST_CH_TEMP) || (ch == `ASST_CH_CMODE)) begin
        chan_gain = `ASST_GAIN_ONE;
      end else begin
        chan_gain = prog;
      end
    end
  endfunction

  // ==================================================
  // Sequencer
  // Launch beats every other event; conv_end is only true in ST_CONV
  // Spurious conversion-done pulses outside ST_CONV are ignored
  always @(posedge i_clk) begin
    if (i_rst) begin
      state          <= ST_IDLE;
      cur_chan       <= 4'h0;
      gap_shutdown   <= 1'b0;
      o_conv_start   <= 1'b0;
      o_mux_sel      <= 8'h00;
      o_gain_sel     <= `ASST_RST_GAIN;
      o_offset_short <= 1'b0;
      o_power_state  <= `ASST_RST_PWR;
      o_data_ready   <= 1'b0;
      o_data         <= 24'h000000;
      o_chan_id      <= 4'h0;
    end else begin
      o_conv_start <= 1'b0;
      o_data_ready <= 1'b0;
      if (conv_end) begin
        o_data       <= i_conv_data;
        o_chan_id    <= cur_chan;
        o_data_ready <= 1'b1;
      end
      if (launch) begin
        state          <= ST_CONV;
        cur_chan       <= first_idx;
        o_mux_sel      <= chan_mux(first_idx);
        o_gain_sel     <= chan_gain(first_idx, cfg_gain);
        o_offset_short <= (first_idx == `ASST_CH_OFFSET);
        o_power_state  <= `ASST_PWR_ACTIVE;
        o_conv_start   <= 1'b1;
      end else if (conv_end && next_found) begin
        // Mux moves now so the input settles over the whole delay
        cur_chan       <= next_idx;
        o_mux_sel      <= chan_mux(next_idx);
        o_gain_sel     <= chan_gain(next_idx, cfg_gain);
        o_offset_short <= (next_idx == `ASST_CH_OFFSET);
        if (dly_used) begin
          state         <= ST_DLY;
          o_power_state <= `ASST_PWR_STANDBY;
        end else begin
          o_conv_start <= 1'b1;
        end
      end else if (gap_load) begin
        state <= ST_GAP;
        if (scan_cycle_interval > `ASST_SETUP_PERIODS) begin
          gap_shutdown  <= 1'b1;
          o_power_state <= `ASST_PWR_SHUTDOWN;
        end else begin
          gap_shutdown  <= 1'b0;
          o_power_state <= `ASST_PWR_STANDBY;
        end
      end else if (conv_end) begin
        state         <= ST_IDLE;
        o_power_state <= `ASST_PWR_STANDBY;
      end else if (dly_done) begin
        state         <= ST_CONV;
        o_power_state <= `ASST_PWR_ACTIVE;
        o_conv_start  <= 1'b1;
      end else if ((state == ST_GAP) && gap_shutdown && (cnt_count == `ASST_SETUP_PERIODS)) begin
        o_power_state <= `ASST_PWR_ACTIVE;
      end
    end
  end

  // ==================================================
  // Register writes
  // Writes during a scan store fields only; nothing restarts
  always @(posedge i_clk) begin
    if (i_rst) begin
      cfg_power                <= `ASST_RST_PWR;
      cfg_gain                 <= `ASST_RST_GAIN;
      conversion_repeat_select <= `ASST_RST_REP;
      scan_mask                <= `ASST_RST_MASK;
      intra_scan_delay         <= `ASST_RST_DLY;
      scan_cycle_interval      <= `ASST_RST_INTERVAL;
      offset_correction_value  <= `ASST_RST_OFFCORR;
    end else begin
      // A single cycle ending drops the mode to standby; a write that cycle wins
      if (conv_end && !next_found && !repeat_on) begin
        cfg_power <= `ASST_PWR_STANDBY;
      end
      if (wr_config) begin
        cfg_power                <= i_reg_wdata[`ASST_CFG_PWR_MSB:`ASST_CFG_PWR_LSB];
        cfg_gain                 <= i_reg_wdata[`ASST_CFG_GAIN_MSB:`ASST_CFG_GAIN_LSB];
        conversion_repeat_select <= i_reg_wdata[`ASST_CFG_REP_MSB:`ASST_CFG_REP_LSB];
      end else if (i_reg_wr && (i_reg_addr == `ASST_ADDR_SCAN)) begin
        scan_mask        <= i_reg_wdata[`ASST_SCAN_MASK_MSB:`ASST_SCAN_MASK_LSB];
        intra_scan_delay <= i_reg_wdata[`ASST_SCAN_DLY_MSB:`ASST_SCAN_DLY_LSB];
      end else if (i_reg_wr && (i_reg_addr == `ASST_ADDR_INTERVAL)) begin
        scan_cycle_interval <= i_reg_wdata;
      end else if (i_reg_wr && (i_reg_addr == `ASST_ADDR_OFFCORR)) begin
        offset_correction_value <= i_reg_wdata;
      end
    end
  end

  // ==================================================
  // Register reads and status
  // Read data holds until the next read strobe
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_reg_rdata         <= 24'h000000;
      o_offset_correction <= `ASST_RST_OFFCORR;
      o_scan_active       <= 1'b0;
    end else begin
      o_offset_correction <= offset_correction_value;
      o_scan_active       <= (state != ST_IDLE);
      if (i_reg_rd && (i_reg_addr == `ASST_ADDR_CONFIG)) begin
        // Internal power state is hidden while a scan runs
        o_reg_rdata <= {16'h0000, conversion_repeat_select, 1'b0, cfg_gain,
                        ((state != ST_IDLE) ? `ASST_PWR_ACTIVE : cfg_power)};
      end else if (i_reg_rd && (i_reg_addr == `ASST_ADDR_SCAN)) begin
        o_reg_rdata <= {intra_scan_delay, 5'h00, scan_mask};
      end else if (i_reg_rd && (i_reg_addr == `ASST_ADDR_INTERVAL)) begin
        o_reg_rdata <= scan_cycle_interval;
      end else if (i_reg_rd && (i_reg_addr == `ASST_ADDR_OFFCORR)) begin
        o_reg_rdata <= offset_correction_value;
      end else if (i_reg_rd) begin
        o_reg_rdata <= 24'h000000;
      end
    end
  end

endmodule

`default_nettype wire
